/* File: hw/cmd_decoder.sv */
// module: device end, decodes the command bus and tracks power and burst state
//
// Functional notes
// - mode_register_seven writes have no effect
// - bg/ba all ones mode write ignored
// - controller passes mode write address bits A13..A0 unchanged
// - decode from select, act, shared pins, cke
// - act low turns shared pins to row bits
// - reset pin is asynchronous only
// - bg/ba pick bank or mode register
// - bursts run to end, length per mode
// - no refresh while powered down
// - odt ignored by decode, off in self refresh
// - controller makes self refresh exit synchronous
// - nop only gear-down entry or power-save exit; decode also takes nop with cke falling as power-down entry
// - deselect: no new command, work continues
// - self refresh entry only when idle
module cmd_decoder
  import cmd_decode_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // command bus
  cmd_bus_if.dev                 bus,
  // decoded command
  output logic                   cmdValid_r,
  output cmd_type                cmd_r,
  output logic [BG_W-1:0]        bankGroup_r,
  output logic [BA_W-1:0]        bank_r,
  output logic [16:0]            rowAddr_r,
  output logic [ADDR_W-1:0]      colOp_r,
  output logic                   autoPre_r,
  output logic                   chop_r,
  // device state
  output pstate_type             pstate_r,
  output logic                   burstBusy_r,
  output logic                   refreshing_r,
  output logic                   odtActive_r,
  output logic [1:0]             burstMode_r,
  output logic [MR_W-1:0]        lastMr_r,
  output logic                   mrWrite_r
);

  // ---------------------------------------------------------------------------
  // combinational decode
  // ---------------------------------------------------------------------------
  logic    ckePrev_r;
  logic    rstN;
  cmd_type cmdNxt;
  logic    [MR_W-1:0] mrSel;
  logic    [2:0] burstCnt_r;

  assign rstN  = arst_n & bus.resetN;
  assign mrSel = {bus.bg, bus.ba};

  // classify one sampled cycle
  function automatic cmd_type classify(input logic cp, input logic cn, input logic cs,
                                       input logic act, input logic r, input logic c,
                                       input logic w, input logic a10);
    cmd_type res;
    res = CMD_ILLEGAL;
    if (cp && !cn) begin
      if (cs)                                  res = CMD_PDE;
      else if (act && r && c && w)             res = CMD_PDE;
      else if (act && !r && !c && w)           res = CMD_SRE;
    end else if (!cp && cn) begin
      if (cs || (act && r && c && w))          res = CMD_PDX;   // srx resolved by state
    end else if (!cp && !cn) begin
      res = CMD_DES;                                         // held low: don't care
    end else if (cs) begin
      res = CMD_DES;
    end else if (!act) begin
      res = CMD_ACT;
    end else begin
      case ({r, c, w})
        3'b000:  res = CMD_MRS;
        3'b001:  res = CMD_REF;
        3'b010:  res = a10 ? CMD_PREA : CMD_PRE;
        3'b011:  res = CMD_RFU;
        3'b100:  res = CMD_WR;
        3'b101:  res = CMD_RD;
        3'b110:  res = a10 ? CMD_ZQCL : CMD_ZQCS;
        3'b111:  res = CMD_NOP;
        default: res = CMD_ILLEGAL;
      endcase
    end
    return res;
  endfunction : classify

  // burst chop picked by the mode register, or per access by the chop bit (low = chop)
  function automatic logic chopSel(input logic [1:0] mode, input logic bcBit);
    return (mode == BL_FIXED4) || (mode == BL_OTF && !bcBit);
  endfunction : chopSel

  // odt is deliberately absent from the decode inputs
  always_comb begin
    cmdNxt = classify(ckePrev_r, bus.cke, bus.csN, bus.actN, bus.rasNA16,
                      bus.casNA15, bus.weNA14, bus.addr[AP_BIT]);
    if (cmdNxt == CMD_PDX && pstate_r == ST_SREF) begin
      cmdNxt = CMD_SRX;
    end
  end

  // ---------------------------------------------------------------------------
  // cke history
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) ckePrev_r <= 1'b1;  // cke idles high: no false exit right after reset
    else       ckePrev_r <= bus.cke;
  end

  // ---------------------------------------------------------------------------
  // registered command output
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      cmdValid_r  <= 1'b0;
      cmd_r       <= CMD_DES;
      bankGroup_r <= '0;
      bank_r      <= '0;
      rowAddr_r   <= '0;
      colOp_r     <= '0;
      autoPre_r   <= 1'b0;
      chop_r      <= 1'b0;
    end else begin
      cmd_r       <= cmdNxt;
      cmdValid_r  <= (cmdNxt != CMD_DES) && (cmdNxt != CMD_NOP) &&
                     (cmdNxt != CMD_RFU) && (cmdNxt != CMD_ILLEGAL) &&
                     !(cmdNxt == CMD_MRS && mrSel == MR_RCW);
      bankGroup_r <= bus.bg;
      bank_r      <= bus.ba;
      rowAddr_r   <= {bus.rasNA16, bus.casNA15, bus.weNA14, bus.addr};
      colOp_r     <= bus.addr;
      autoPre_r   <= bus.addr[AP_BIT];
      chop_r      <= chopSel(burstMode_r, bus.addr[BC_BIT]);
    end
  end

  // ---------------------------------------------------------------------------
  // mode register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      burstMode_r <= BL_FIXED8;
      lastMr_r    <= '0;
      mrWrite_r   <= 1'b0;
    end else begin
      mrWrite_r <= 1'b0;
      if (cmdNxt == CMD_MRS && mrSel != MR_RCW && mrSel != MR_SEVEN) begin
        mrWrite_r <= 1'b1;
        lastMr_r  <= mrSel;
        if (mrSel == MR_BURST) burstMode_r <= bus.addr[1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) pstate_r <= ST_ACTIVE;
    else begin
      case (pstate_r)
        ST_ACTIVE: begin
          if (cmdNxt == CMD_SRE)      pstate_r <= ST_SREF;
          else if (cmdNxt == CMD_PDE) pstate_r <= ST_PDOWN;
        end
        ST_PDOWN:  if (cmdNxt == CMD_PDX) pstate_r <= ST_ACTIVE;
        ST_SREF:   if (cmdNxt == CMD_SRX) pstate_r <= ST_ACTIVE;
        default:   pstate_r <= ST_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // refresh activity and odt gating
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      refreshing_r <= 1'b0;
      odtActive_r  <= 1'b0;
    end else begin
      refreshing_r <= (cmdNxt == CMD_REF && pstate_r == ST_ACTIVE) ||
                      (pstate_r == ST_SREF && cmdNxt != CMD_SRX);
      odtActive_r  <= bus.odt && pstate_r != ST_SREF &&
                      cmdNxt != CMD_SRE;
    end
  end

  // ---------------------------------------------------------------------------
  // burst tracker: runs to completion, nothing cuts it short
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      burstCnt_r  <= '0;
      burstBusy_r <= 1'b0;
    end else if (burstCnt_r == '0 && (cmdNxt == CMD_RD || cmdNxt == CMD_WR)) begin
      burstCnt_r  <= chopSel(burstMode_r, bus.addr[BC_BIT]) ? BURST_CYC4 : BURST_CYC8;
      burstBusy_r <= 1'b1;
    end else if (burstCnt_r != '0) begin
      burstCnt_r  <= burstCnt_r - 3'h1;
      burstBusy_r <= burstCnt_r != 3'h1;
    end
  end

endmodule : cmd_decoder

/* File: hw/cmd_decode_pkg.sv */
// package: command encodings, pin layout and decoder state for the command decoder
package cmd_decode_pkg;

  // ---------------------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W   = 14;        // A13..A0 carried beside the shared pins
  localparam int BG_W     = 1;
  localparam int BA_W     = 2;
  localparam int MR_W     = 3;
  localparam int OP_W     = 14;

  // ---------------------------------------------------------------------------
  // address bit positions
  // ---------------------------------------------------------------------------
  localparam int AP_BIT   = 10;        // auto precharge / all banks / zq long
  localparam int BC_BIT   = 12;        // burst chop on the fly (low = chop)

  // ---------------------------------------------------------------------------
  // mode register selects
  // ---------------------------------------------------------------------------
  localparam logic [MR_W-1:0] MR_SEVEN    = 3'h7;  // mode_register_seven
  localparam logic [MR_W-1:0] MR_RCW      = 3'h7;  // bg/ba all ones: control words
  localparam logic [MR_W-1:0] MR_BURST    = 3'h0;  // register holding burst length
  localparam logic [1:0]      BL_FIXED8   = 2'h0;
  localparam logic [1:0]      BL_OTF      = 2'h1;
  localparam logic [1:0]      BL_FIXED4   = 2'h2;

  // ---------------------------------------------------------------------------
  // burst timing in clocks (data beats / 2)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BURST_CYC8 = 3'h4;
  localparam logic [2:0] BURST_CYC4 = 3'h2;

  // ---------------------------------------------------------------------------
  // decoded commands
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_DES     = 5'h00,
    CMD_NOP     = 5'h01,
    CMD_MRS     = 5'h02,
    CMD_REF     = 5'h03,
    CMD_SRE     = 5'h04,
    CMD_SRX     = 5'h05,
    CMD_PRE     = 5'h06,
    CMD_PREA    = 5'h07,
    CMD_RFU     = 5'h08,
    CMD_ACT     = 5'h09,
    CMD_WR      = 5'h0A,
    CMD_RD      = 5'h0B,
    CMD_PDE     = 5'h0C,
    CMD_PDX     = 5'h0D,
    CMD_ZQCL    = 5'h0E,
    CMD_ZQCS    = 5'h0F,
    CMD_ILLEGAL = 5'h10
  } cmd_type;

  // ---------------------------------------------------------------------------
  // device power state
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_PDOWN  = 2'b01,
    ST_SREF   = 2'b10
  } pstate_type;

endpackage : cmd_decode_pkg

/* File: hw/cmd_bus_if.sv */
// interface: command/address bus between controller and device
interface cmd_bus_if;
  import cmd_decode_pkg::*;
  logic              resetN;
  logic              cke;
  logic              csN;
  logic              actN;
  logic              rasNA16;
  logic              casNA15;
  logic              weNA14;
  logic [BG_W-1:0]   bg;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              odt;

  modport ctrl (output resetN, cke, csN, actN, rasNA16, casNA15, weNA14, bg, ba, addr, odt);
  modport dev  (input  resetN, cke, csN, actN, rasNA16, casNA15, weNA14, bg, ba, addr, odt);
endinterface : cmd_bus_if

/* File: hw/cmd_issuer.sv */
// module: controller end, drives at most one command per request onto the bus (none for a self refresh request while banks busy)
module cmd_issuer
  import cmd_decode_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // user request
  input  wire logic              reqValid,
  input  wire cmd_type           reqCmd,
  input  wire logic [BG_W-1:0]   reqBg,
  input  wire logic [BA_W-1:0]   reqBa,
  input  wire logic [16:0]       reqAddr,
  input  wire logic              reqOdt,
  input  wire logic              banksIdle,
  output logic                   reqReady_r,
  // command bus
  cmd_bus_if.ctrl                bus
);

  // ---------------------------------------------------------------------------
  // bus registers
  // ---------------------------------------------------------------------------
  logic              cke_r, cs_r, act_r, r_r, c_r, w_r, odt_r, rst_r;
  logic [BG_W-1:0]   bg_r;
  logic [BA_W-1:0]   ba_r;
  logic [ADDR_W-1:0] a_r;

  assign bus.resetN  = rst_r;
  assign bus.cke     = cke_r;
  assign bus.csN     = cs_r;
  assign bus.actN    = act_r;
  assign bus.rasNA16 = r_r;
  assign bus.casNA15 = c_r;
  assign bus.weNA14  = w_r;
  assign bus.bg      = bg_r;
  assign bus.ba      = ba_r;
  assign bus.addr    = a_r;
  assign bus.odt     = odt_r;

  // one command per clock; self refresh requests dropped while banks busy
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_r <= 1'b0; cke_r <= 1'b1; cs_r <= 1'b1; act_r <= 1'b1;
      r_r <= 1'b1; c_r <= 1'b1; w_r <= 1'b1; odt_r <= 1'b0;
      bg_r <= '0; ba_r <= '0; a_r <= '0; reqReady_r <= 1'b0;
    end else begin
      rst_r <= 1'b1;
      reqReady_r <= 1'b1;
      odt_r <= reqOdt;
      cs_r  <= 1'b1;                                              // deselect by default
      act_r <= 1'b1; r_r <= 1'b1; c_r <= 1'b1; w_r <= 1'b1;
      bg_r <= reqBg; ba_r <= reqBa; a_r <= reqAddr[ADDR_W-1:0];
      if (reqValid && reqReady_r) begin
        case (reqCmd)
          CMD_MRS:  begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b000;
                          a_r <= reqAddr[OP_W-1:0]; end
          CMD_REF:  begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b001; end
          CMD_SRE:  if (banksIdle) begin
                      cs_r <= 1'b0; cke_r <= 1'b0; {r_r, c_r, w_r} <= 3'b001; end
          CMD_SRX,
          CMD_PDX:  cke_r <= 1'b1;
          CMD_PDE:  cke_r <= 1'b0;
          CMD_PRE,
          CMD_PREA: begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b010;
                          a_r[AP_BIT] <= (reqCmd == CMD_PREA); end
          CMD_ACT:  begin cs_r <= 1'b0; act_r <= 1'b0;
                          {r_r, c_r, w_r} <= reqAddr[16:14]; end
          CMD_WR:   begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b100; end
          CMD_RD:   begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b101; end
          CMD_ZQCL,
          CMD_ZQCS: begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b110;
                          a_r[AP_BIT] <= (reqCmd == CMD_ZQCL); end
          CMD_RFU:  begin cs_r <= 1'b0; {r_r, c_r, w_r} <= 3'b011; end  // far end must ignore
          CMD_NOP:  cs_r <= 1'b0;
          default:  cs_r <= 1'b1;
        endcase
      end
    end
  end

endmodule : cmd_issuer

/* File: verification/cmd_decoder_monitor.sv */
// checker: properties tying the command bus to the decoder outputs
module cmd_decoder_monitor
  import cmd_decode_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // command bus
  input wire logic              resetN,
  input wire logic              cke,
  input wire logic              csN,
  input wire logic              actN,
  input wire logic              rasNA16,
  input wire logic              casNA15,
  input wire logic              weNA14,
  input wire logic [BG_W-1:0]   bg,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr,
  // decoder outputs
  input wire logic              cmdValid_r,
  input wire cmd_type           cmd_r,
  input wire logic [16:0]       rowAddr_r,
  input wire logic              autoPre_r,
  input wire logic              chop_r,
  input wire pstate_type        pstate_r,
  input wire logic              burstBusy_r,
  input wire logic              refreshing_r,
  input wire logic              odtActive_r,
  input wire logic              mrWrite_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ckePrev_r;
  logic sel;
  logic a10;
  logic mrs;

  // cke of the previous edge, high in reset like the issuer drives it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) ckePrev_r <= 1'b1;
    else ckePrev_r <= cke;
  end

  // a command edge: selected, out of reset, cke high on both edges
  assign sel = !csN && resetN && cke && ckePrev_r;
  assign a10 = addr[AP_BIT];
  assign mrs = sel && actN && !rasNA16 && !casNA15 && !weNA14;

  default clocking mon_cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  rcw_ignore_a: assert property (mrs && {bg, ba} == MR_RCW
    |=> !mrWrite_r && !cmdValid_r) else $error("reserved mode write acted on");
  mr_write_a: assert property (mrs && {bg, ba} != MR_RCW
    |=> mrWrite_r && cmd_r == CMD_MRS) else $error("mode write not taken");
  act_row_a: assert property (sel && !actN |=> cmdValid_r && cmd_r == CMD_ACT
    && rowAddr_r[16:14] == {$past(rasNA16), $past(casNA15), $past(weNA14)})
    else $error("activate row bits wrong");
  rw_kind_a: assert property (sel && actN && rasNA16 && !casNA15 |=> cmdValid_r
    && cmd_r == ($past(weNA14) ? CMD_RD : CMD_WR) && autoPre_r == $past(a10))
    else $error("read or write decoded wrong");
  pre_kind_a: assert property (sel && actN && !rasNA16 && casNA15 && !weNA14
    |=> cmd_r == ($past(a10) ? CMD_PREA : CMD_PRE)) else $error("precharge kind wrong");
  zq_kind_a: assert property (sel && actN && rasNA16 && casNA15 && !weNA14
    |=> cmd_r == ($past(a10) ? CMD_ZQCL : CMD_ZQCS)) else $error("calibration kind wrong");
  no_effect_a: assert property (sel && actN && casNA15 && weNA14
    |=> !cmdValid_r) else $error("no-effect encoding flagged");
  deselect_a: assert property (csN && resetN && cke && ckePrev_r
    |=> !cmdValid_r) else $error("command taken while deselected");
  pdown_quiet_a: assert property (pstate_r == ST_PDOWN |-> !refreshing_r)
    else $error("refresh during power-down");
  sref_odt_a: assert property (pstate_r == ST_SREF |-> !odtActive_r)
    else $error("termination on in self refresh");
  burst_full_a: assert property (cmdValid_r && cmd_r inside {CMD_RD, CMD_WR}
    && !chop_r && !$past(burstBusy_r) |-> burstBusy_r [*4]) else $error("long burst cut");
  burst_chop_a: assert property (cmdValid_r && cmd_r inside {CMD_RD, CMD_WR}
    && chop_r && !$past(burstBusy_r) |-> burstBusy_r [*2] ##1 (!burstBusy_r || cmdValid_r))
    else $error("chopped burst length wrong");

  // main scenarios
  cover property (cmdValid_r && chop_r);
  cover property (pstate_r == ST_SREF);
  cover property (pstate_r == ST_PDOWN);
  cover property (mrs && {bg, ba} == MR_RCW);
endmodule : cmd_decoder_monitor

/* File: verification/ddr4_command_decoder_tb_top.sv */
// testbench: issuer and decoder joined by the command bus
module ddr4_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_decode_pkg::*;

  typedef struct {cmd_type c; logic [2:0] bk; logic [16:0] row; logic ap; logic ch;} note_type;

  logic clk_sys, arst_n, reqValid, reqOdt, banksIdle, reqReady_r;
  cmd_type reqCmd, cmd_r;
  logic [BG_W-1:0] reqBg, bankGroup_r;
  logic [BA_W-1:0] reqBa, bank_r;
  logic [16:0] reqAddr, rowAddr_r, a;
  logic cmdValid_r, autoPre_r, chop_r, burstBusy_r, refreshing_r, odtActive_r, mrWrite_r;
  pstate_type pstate_r;
  logic [1:0] burstMode_r, mode;
  logic [ADDR_W-1:0] colOp_r;
  logic [MR_W-1:0] lastMr_r;
  logic [31:0] seed = 32'h6B6D80DB;
  note_type notes[$];
  note_type exp;
  int fails = 0;
  int comparisons = 0;
  cmd_type cmdTable [12] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_NOP, CMD_PRE, CMD_PREA, CMD_RFU,
                             CMD_ZQCL, CMD_ZQCS, CMD_REF, CMD_ACT, CMD_WR};

  cmd_bus_if cmd_bus_if_i ();
  cmd_issuer cmd_issuer_i (.clk_sys(clk_sys), .arst_n(arst_n), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqBg(reqBg), .reqBa(reqBa), .reqAddr(reqAddr), .reqOdt(reqOdt),
    .banksIdle(banksIdle), .reqReady_r(reqReady_r), .bus(cmd_bus_if_i));
  cmd_decoder cmd_decoder_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus(cmd_bus_if_i),
    .cmdValid_r(cmdValid_r), .cmd_r(cmd_r), .bankGroup_r(bankGroup_r), .bank_r(bank_r),
    .rowAddr_r(rowAddr_r), .colOp_r(colOp_r), .autoPre_r(autoPre_r), .chop_r(chop_r),
    .pstate_r(pstate_r), .burstBusy_r(burstBusy_r), .refreshing_r(refreshing_r),
    .odtActive_r(odtActive_r), .burstMode_r(burstMode_r), .lastMr_r(lastMr_r),
    .mrWrite_r(mrWrite_r));
  cmd_decoder_monitor cmd_decoder_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .resetN(cmd_bus_if_i.resetN), .cke(cmd_bus_if_i.cke), .csN(cmd_bus_if_i.csN),
    .actN(cmd_bus_if_i.actN), .rasNA16(cmd_bus_if_i.rasNA16), .casNA15(cmd_bus_if_i.casNA15),
    .weNA14(cmd_bus_if_i.weNA14), .bg(cmd_bus_if_i.bg), .ba(cmd_bus_if_i.ba),
    .addr(cmd_bus_if_i.addr), .cmdValid_r(cmdValid_r), .cmd_r(cmd_r), .rowAddr_r(rowAddr_r),
    .autoPre_r(autoPre_r), .chop_r(chop_r), .pstate_r(pstate_r), .burstBusy_r(burstBusy_r),
    .refreshing_r(refreshing_r), .odtActive_r(odtActive_r), .mrWrite_r(mrWrite_r));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // one request, held until taken; the expected decode is noted when asked
  task automatic issue(input cmd_type c, input logic [2:0] bk, input logic [16:0] ad,
                       input bit noted);
    note_type n;
    seed = lfsr(seed);
    reqValid <= 1'b1;
    reqCmd <= c;
    {reqBg, reqBa} <= bk;
    reqAddr <= ad;
    reqOdt <= seed[5];  // termination toggles freely
    do @(posedge clk_sys); while (reqReady_r !== 1'b1);
    if (c == CMD_MRS && bk == MR_BURST) mode = ad[1:0];
    n.c = c;
    n.bk = bk;
    n.row = ad;
    n.ap = ad[AP_BIT];
    n.ch = (mode == BL_FIXED4) || (mode == BL_OTF && !ad[BC_BIT]);
    if (noted) notes.push_back(n);
  endtask : issue

  task automatic idle(input int n);
    reqValid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // clock
  always #5 clk_sys = ~clk_sys;

  // result watcher: each flagged command takes the oldest note
  always @(negedge clk_sys) begin
    if (arst_n && cmdValid_r === 1'b1) begin
      if (notes.size() == 0) check("unexpected command", 32'h1, 32'h0);
      else begin
        exp = notes.pop_front();
        check("command", 32'(cmd_r), 32'(exp.c));
        if (exp.c inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS})
          check("bank", 32'({bankGroup_r, bank_r}), 32'(exp.bk));
        if (exp.c == CMD_ACT) check("row", 32'(rowAddr_r), 32'(exp.row));
        if (exp.c inside {CMD_RD, CMD_WR}) begin
          check("autoPre", 32'(autoPre_r), 32'(exp.ap));
          check("chop", 32'(chop_r), 32'(exp.ch));
          check("column", 32'(colOp_r), 32'(exp.row[ADDR_W-1:0]));
        end
      end
    end
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = CMD_DES;
    {reqBg, reqBa} = 3'h0;
    reqAddr = 17'h00000;
    reqOdt = 1'b0;
    banksIdle = 1'b1;
    mode = BL_FIXED8;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;  // bus reset pin then stays high
    // every encoding but mode write and power states back to back, random banks and addresses
    repeat (3) begin
      foreach (cmdTable[i]) begin
        seed = lfsr(seed);
        a = seed[16:0];
        if (cmdTable[i] inside {CMD_PRE, CMD_ZQCS}) a[AP_BIT] = 1'b0;
        if (cmdTable[i] inside {CMD_PREA, CMD_ZQCL}) a[AP_BIT] = 1'b1;
        issue(cmdTable[i], seed[19:17], a, !(cmdTable[i] inside {CMD_NOP, CMD_RFU}));
      end
    end
    idle(6);
    // burst length modes, unused mode bits zero
    issue(CMD_MRS, MR_BURST, 17'h00001, 1'b1);
    idle(3);
    check("burstMode", 32'(burstMode_r), 32'(BL_OTF));
    issue(CMD_RD, 3'h1, 17'h00000, 1'b1);
    idle(7);
    issue(CMD_WR, 3'h2, 17'h01400, 1'b1);
    idle(7);
    issue(CMD_MRS, 3'h3, 17'h00000, 1'b1);
    idle(3);
    check("lastMr", 32'(lastMr_r), 32'h3);
    issue(CMD_MRS, MR_SEVEN, 17'h00002, 1'b0);
    idle(3);
    check("burstMode", 32'(burstMode_r), 32'(BL_OTF));
    check("lastMr", 32'(lastMr_r), 32'h3);
    issue(CMD_MRS, MR_BURST, 17'h00002, 1'b1);
    idle(3);
    check("burstMode", 32'(burstMode_r), 32'(BL_FIXED4));
    issue(CMD_RD, 3'h5, 17'h01000, 1'b1);
    idle(7);
    // power-down, refused and accepted self refresh
    issue(CMD_PDE, 3'h0, 17'h00000, 1'b1);
    idle(4);
    check("pstate", 32'(pstate_r), 32'(ST_PDOWN));
    check("refreshing", 32'(refreshing_r), 32'h0);
    issue(CMD_PDX, 3'h0, 17'h00000, 1'b1);
    idle(4);
    banksIdle <= 1'b0;
    issue(CMD_SRE, 3'h0, 17'h00000, 1'b0);  // dropped while busy
    idle(4);
    check("pstate", 32'(pstate_r), 32'(ST_ACTIVE));
    banksIdle <= 1'b1;
    issue(CMD_SRE, 3'h0, 17'h00000, 1'b1);
    reqOdt <= 1'b1;  // termination asked for while in self refresh
    idle(6);
    check("pstate", 32'(pstate_r), 32'(ST_SREF));
    check("odt", 32'(odtActive_r), 32'h0);
    issue(CMD_SRX, 3'h0, 17'h00000, 1'b1);  // exit on a clock edge
    idle(8);
    check("odt", 32'(odtActive_r), 32'h1);
    check("notes left", 32'(notes.size()), 32'h0);
    stop_test();
  end
endmodule : ddr4_command_decoder_tb_top
